// [inc/otp_pkg.sv]
// Contract
// - read shifts trim out from pulse 28
// - command 01 loads words unless locked
// - command 10 fuses volatile trim unless locked
// - fuse frame ignores its own shifted data
// - bad unlock or command 00 abandons frame
// - clock gap over 100 us times out
// - extra pulses ignored; exit on timeout, or at once on bad unlock or command 00
// - bits 20..35 set magnetic offset trims
// - bits 36..51 set electronic offset trims
// - bits 52..67 set gain trims
// - bit 70 selects 8 or 12 mT
// - frame is unlock, command, control, trim
// - one bit captured per rising clock edge
package otp_pkg;
	localparam int UNLOCK_W = 8;
	localparam int CMD_W    = 2;
	localparam int HDR_W    = UNLOCK_W + CMD_W;
	localparam int CTRL_W   = 16;
	localparam int TRIM_W   = 80;
	localparam int POS_W    = 7;
	localparam int FIELD_W  = 8;

	localparam logic [UNLOCK_W-1:0] UNLOCK_CODE = 8'hf2;
	localparam logic [CMD_W-1:0]    CMD_NORMAL  = 2'h0;
	localparam logic [CMD_W-1:0]    CMD_WRITE   = 2'h1;
	localparam logic [CMD_W-1:0]    CMD_FUSE    = 2'h2;
	localparam logic [CMD_W-1:0]    CMD_READ    = 2'h3;

	// pulse numbers, counted from 1 at the entry pulse
	localparam logic [POS_W-1:0] POS_FIRST  = 7'h01;
	localparam logic [POS_W-1:0] HDR_LAST   = 7'h0a;
	localparam logic [POS_W-1:0] CTRL_LAST  = 7'h1a;
	localparam logic [POS_W-1:0] READ_FIRST = 7'h1c;
	localparam logic [POS_W-1:0] FRAME_LAST = 7'h6a;

	localparam int LOCK_BIT   = 76;
	localparam int MAG_L_LSB  = 20;
	localparam int MAG_R_LSB  = 28;
	localparam int ELEC_L_LSB = 36;
	localparam int ELEC_R_LSB = 44;
	localparam int GAIN_L_LSB = 52;
	localparam int GAIN_R_LSB = 60;
	localparam int FSR_BIT    = 70;

	localparam logic [CTRL_W-1:0] CTRL_RESET = 16'h0000;
	localparam logic [TRIM_W-1:0] TRIM_RESET = 80'h0;

	localparam int TIMEOUT_US  = 100;
	localparam int CLK_MHZ     = 125;
	localparam int TIMEOUT_CYC = TIMEOUT_US * CLK_MHZ;

	typedef struct packed {
		logic [CMD_W-1:0]  cmd;
		logic [CTRL_W-1:0] ctrl;
		logic [TRIM_W-1:0] trim;
	} frame_t;

	typedef enum logic [2:0] {
		LK_IDLE,
		LK_HDR,
		LK_BODY,
		LK_DONE,
		LK_ABORT
	} link_state_t;

	typedef enum logic [1:0] {
		SY_NORMAL,
		SY_ACTIVE
	} sys_state_t;
endpackage

// [rtl/bit_sync.sv]
`timescale 1ns/10ps
`default_nettype none
module bit_sync #(
	parameter int W = 1
) (
	// clock and reset
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	// levels
	input  wire logic [W-1:0] async_i,
	output logic      [W-1:0] sync_o
);
	logic [W-1:0] meta_q;
	logic [W-1:0] stage_q;

	genvar g;
	generate
		for (g = 0; g < W; g++) begin : g_bit
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					meta_q[g]  <= 1'b0;
					stage_q[g] <= 1'b0;
				end else begin
					meta_q[g]  <= async_i[g];
					stage_q[g] <= meta_q[g];
				end
			end
		end
	endgenerate

	assign sync_o = stage_q;
endmodule
`default_nettype wire

// [rtl/gap_timer.sv]
`timescale 1ns/10ps
`default_nettype none
module gap_timer #(
	parameter int LIMIT = 12500
) (
	// clock and reset
	input  wire logic clk_i,
	input  wire logic rst_i,
	// control
	input  wire logic run_i,
	input  wire logic restart_i,
	output logic      expired_o
);
	localparam int CNT_W = $clog2(LIMIT + 1);
	localparam logic [CNT_W-1:0] CNT_LIM = CNT_W'(LIMIT);

	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] cnt_d;

	always_comb begin
		cnt_d = cnt_q;
		if (restart_i || !run_i) begin
			cnt_d = '0;
		end else if (cnt_q != CNT_LIM) begin
			cnt_d = cnt_q + CNT_W'(1);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	// a full count with no fresh edge means the gap was too long
	assign expired_o = run_i && !restart_i && (cnt_q == CNT_LIM);
endmodule
`default_nettype wire

// [rtl/otp_trim_port.sv]
`timescale 1ns/10ps
`default_nettype none
module otp_trim_port
	import otp_pkg::*;
#(
	parameter int                TIMEOUT_CYCLES = TIMEOUT_CYC,
	parameter logic [TRIM_W-1:0] FACTORY_TRIM   = TRIM_RESET
) (
	// system clock and reset
	input  wire logic                clk_i,
	input  wire logic                rst_i,
	// programming clock and entry detect from the test pin
	input  wire logic                prog_clk_i,
	input  wire logic                hv_entry_i,
	// serial data pin
	input  wire logic                program_serial_line_i,
	output logic                     program_serial_line_o,
	output logic                     program_serial_line_oe_n_o,
	// mode and stored words
	output logic                     test_mode_o,
	output logic [CTRL_W-1:0]        mux_control_word_o,
	output logic [TRIM_W-1:0]        trim_fuse_word_o,
	output logic [TRIM_W-1:0]        fused_trim_word_o,
	// decoded trim fields
	output logic [FIELD_W-1:0]       left_magnetic_offset_trim_o,
	output logic [FIELD_W-1:0]       right_magnetic_offset_trim_o,
	output logic [FIELD_W-1:0]       left_electronic_offset_trim_o,
	output logic [FIELD_W-1:0]       right_electronic_offset_trim_o,
	output logic [FIELD_W-1:0]       left_gain_trim_o,
	output logic [FIELD_W-1:0]       right_gain_trim_o,
	output logic                     full_scale_range_select_o
);
	function automatic logic [FIELD_W-1:0] trim_field(
		input logic [TRIM_W-1:0] word,
		input int                lsb
	);
		trim_field = word[lsb +: FIELD_W];
	endfunction

	// link domain, clocked by the programming clock
	logic                link_rst;
	link_state_t         lk_q;
	link_state_t         lk_d;
	logic [POS_W-1:0]    pos_q;
	logic [POS_W-1:0]    pos_d;
	logic [HDR_W-1:0]    hdr_q;
	logic [HDR_W-1:0]    hdr_d;
	frame_t              frm_q;
	frame_t              frm_d;
	logic                edge_tgl_q;
	logic                edge_tgl_d;
	logic                end_tgl_q;
	logic                end_tgl_d;
	logic                bad_q;
	logic                bad_d;
	logic                rd_lvl_q;
	logic                rd_lvl_d;
	logic                sout_q;
	logic                sout_d;
	logic [POS_W-1:0]    rd_idx;

	// system words, read by the link only while they are quiescent
	logic [TRIM_W-1:0]   vol_q;
	logic [TRIM_W-1:0]   vol_d;

	bit_sync #(
		.W (1)
	) u_link_rst (
		.clk_i   (prog_clk_i),
		.rst_i   (1'b0),
		.async_i (rst_i),
		.sync_o  (link_rst)
	);

	assign rd_idx = pos_d - READ_FIRST;

	always_comb begin
		lk_d       = lk_q;
		pos_d      = pos_q;
		hdr_d      = hdr_q;
		frm_d      = frm_q;
		edge_tgl_d = edge_tgl_q;
		end_tgl_d  = end_tgl_q;
		bad_d      = bad_q;
		rd_lvl_d   = rd_lvl_q;
		sout_d     = sout_q;
		if (hv_entry_i) begin
			lk_d       = LK_HDR;
			pos_d      = POS_FIRST;
			hdr_d      = {{(HDR_W-1){1'b0}}, program_serial_line_i};
			frm_d      = '0;
			bad_d      = 1'b0;
			rd_lvl_d   = 1'b0;
			edge_tgl_d = ~edge_tgl_q;
		end else begin
			case (lk_q)
				LK_HDR: begin
					edge_tgl_d = ~edge_tgl_q;
					pos_d      = pos_q + POS_W'(1);
					hdr_d      = {hdr_q[HDR_W-2:0], program_serial_line_i};
					if (pos_d == HDR_LAST) begin
						if (hdr_d[HDR_W-1:CMD_W] != UNLOCK_CODE ||
						    hdr_d[CMD_W-1:0] == CMD_NORMAL) begin
							lk_d      = LK_ABORT;
							bad_d     = 1'b1;
							end_tgl_d = ~end_tgl_q;
						end else begin
							lk_d      = LK_BODY;
							frm_d.cmd = hdr_d[CMD_W-1:0];
						end
					end
				end
				LK_BODY: begin
					edge_tgl_d = ~edge_tgl_q;
					pos_d      = pos_q + POS_W'(1);
					if (pos_d <= CTRL_LAST) begin
						frm_d.ctrl = {program_serial_line_i,
						              frm_q.ctrl[CTRL_W-1:1]};
					end else begin
						frm_d.trim = {program_serial_line_i,
						              frm_q.trim[TRIM_W-1:1]};
					end
					if (frm_q.cmd == CMD_READ && pos_d >= READ_FIRST) begin
						rd_lvl_d = 1'b1;
						sout_d   = vol_q[rd_idx];
					end
					if (pos_d == FRAME_LAST) begin
						lk_d      = LK_DONE;
						end_tgl_d = ~end_tgl_q;
					end
				end
				LK_DONE: begin
					// extra pulses only keep the frame alive
					edge_tgl_d = ~edge_tgl_q;
				end
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge prog_clk_i) begin
		if (link_rst) begin
			lk_q       <= LK_IDLE;
			pos_q      <= '0;
			hdr_q      <= '0;
			frm_q      <= '0;
			edge_tgl_q <= 1'b0;
			end_tgl_q  <= 1'b0;
			bad_q      <= 1'b0;
			rd_lvl_q   <= 1'b0;
			sout_q     <= 1'b0;
		end else begin
			lk_q       <= lk_d;
			pos_q      <= pos_d;
			hdr_q      <= hdr_d;
			frm_q      <= frm_d;
			edge_tgl_q <= edge_tgl_d;
			end_tgl_q  <= end_tgl_d;
			bad_q      <= bad_d;
			rd_lvl_q   <= rd_lvl_d;
			sout_q     <= sout_d;
		end
	end

	assign program_serial_line_o = sout_q;

	// system domain
	logic [2:0]          sync_lvl;
	logic                expired;
	logic                ev_edge;
	logic                ev_end;
	sys_state_t          sy_q;
	sys_state_t          sy_d;
	logic                edge_seen_q;
	logic                edge_seen_d;
	logic                end_seen_q;
	logic                end_seen_d;
	logic [CTRL_W-1:0]   ctrl_q;
	logic [CTRL_W-1:0]   ctrl_d;
	logic [TRIM_W-1:0]   fuse_q;
	logic [TRIM_W-1:0]   fuse_d;
	logic                oe_n_q;
	logic                oe_n_d;
	logic                tm_q;
	logic                tm_d;

	// edge and end events cross as toggles, the read flag as a level
	bit_sync #(
		.W (3)
	) u_sys_sync (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.async_i ({rd_lvl_q, end_tgl_q, edge_tgl_q}),
		.sync_o  (sync_lvl)
	);

	assign ev_edge = sync_lvl[0] ^ edge_seen_q;
	assign ev_end  = sync_lvl[1] ^ end_seen_q;

	gap_timer #(
		.LIMIT (TIMEOUT_CYCLES)
	) u_gap (
		.clk_i     (clk_i),
		.rst_i     (rst_i),
		.run_i     (sy_q == SY_ACTIVE),
		.restart_i (ev_edge),
		.expired_o (expired)
	);

	// frame words are held by the link from the end toggle until
	// the next entry pulse, so they are stable when sampled here
	always_comb begin
		sy_d        = sy_q;
		edge_seen_d = sync_lvl[0];
		end_seen_d  = sync_lvl[1];
		ctrl_d      = ctrl_q;
		vol_d       = vol_q;
		fuse_d      = fuse_q;
		case (sy_q)
			SY_NORMAL: begin
				if (ev_edge) begin
					sy_d = SY_ACTIVE;
				end
			end
			SY_ACTIVE: begin
				if (expired) begin
					sy_d = SY_NORMAL;
				end else if (ev_end) begin
					if (bad_q) begin
						sy_d = SY_NORMAL;
					end else if (frm_q.cmd == CMD_WRITE &&
					             !vol_q[LOCK_BIT]) begin
						ctrl_d = frm_q.ctrl;
						vol_d  = frm_q.trim;
					end else if (frm_q.cmd == CMD_FUSE &&
					             !vol_q[LOCK_BIT]) begin
						fuse_d = fuse_q | vol_q;
					end
				end
			end
			default: begin
				sy_d = SY_NORMAL;
			end
		endcase
		tm_d   = (sy_d == SY_ACTIVE);
		oe_n_d = !((sy_d == SY_ACTIVE) && sync_lvl[2]);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sy_q        <= SY_NORMAL;
			edge_seen_q <= 1'b0;
			end_seen_q  <= 1'b0;
			ctrl_q      <= CTRL_RESET;
			vol_q       <= FACTORY_TRIM;
			fuse_q      <= FACTORY_TRIM;
			oe_n_q      <= 1'b1;
			tm_q        <= 1'b0;
		end else begin
			sy_q        <= sy_d;
			edge_seen_q <= edge_seen_d;
			end_seen_q  <= end_seen_d;
			ctrl_q      <= ctrl_d;
			vol_q       <= vol_d;
			fuse_q      <= fuse_d;
			oe_n_q      <= oe_n_d;
			tm_q        <= tm_d;
		end
	end

	assign program_serial_line_oe_n_o = oe_n_q;
	assign test_mode_o                = tm_q;
	assign mux_control_word_o         = ctrl_q;
	assign trim_fuse_word_o           = vol_q;
	assign fused_trim_word_o          = fuse_q;

	assign left_magnetic_offset_trim_o    = trim_field(vol_q, MAG_L_LSB);
	assign right_magnetic_offset_trim_o   = trim_field(vol_q, MAG_R_LSB);
	assign left_electronic_offset_trim_o  = trim_field(vol_q, ELEC_L_LSB);
	assign right_electronic_offset_trim_o = trim_field(vol_q, ELEC_R_LSB);
	assign left_gain_trim_o               = trim_field(vol_q, GAIN_L_LSB);
	assign right_gain_trim_o              = trim_field(vol_q, GAIN_R_LSB);
	assign full_scale_range_select_o      = vol_q[FSR_BIT];
endmodule
`default_nettype wire

// [tb/otp_trim_port_chk.sv]
`timescale 1ns/10ps
`default_nettype none
module otp_trim_port_chk
	import otp_pkg::*;
#(
	parameter int TIMEOUT_CYCLES = 12500
) (
	// clocks and reset
	input wire logic               clk_i,
	input wire logic               rst_i,
	input wire logic               prog_clk_i,
	// watched outputs
	input wire logic               program_serial_line_oe_n_o,
	input wire logic               test_mode_o,
	input wire logic [CTRL_W-1:0]  mux_control_word_o,
	input wire logic [TRIM_W-1:0]  trim_fuse_word_o,
	input wire logic [TRIM_W-1:0]  fused_trim_word_o,
	input wire logic [FIELD_W-1:0] left_magnetic_offset_trim_o,
	input wire logic [FIELD_W-1:0] right_magnetic_offset_trim_o,
	input wire logic               full_scale_range_select_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	logic [TRIM_W-1:0] vol;
	logic [TRIM_W-1:0] fus;
	logic [15:0]       gap_q;
	logic [15:0]       gap_d;
	logic              pc_q;
	assign vol = trim_fuse_word_o;
	assign fus = fused_trim_word_o;
	// system cycles since the programming clock last moved
	always_comb begin
		gap_d = gap_q;
		if (rst_i || prog_clk_i != pc_q)
			gap_d = 16'h0000;
		else if (gap_q != 16'hffff)
			gap_d = gap_q + 16'h0001;
	end
	always_ff @(posedge clk_i) begin
		pc_q  <= prog_clk_i;
		gap_q <= gap_d;
	end
	a_oe_in_frame: assert property (
		$fell(program_serial_line_oe_n_o) |-> test_mode_o)
		else $error("drive outside frame");
	a_lock_freeze: assert property (
		vol[LOCK_BIT] |=> $stable(vol))
		else $error("locked word changed");
	a_idle_hold: assert property (
		!test_mode_o ##1 !test_mode_o |-> $stable(vol)
		&& $stable(mux_control_word_o))
		else $error("words changed while idle");
	a_fuse_gate: assert property (
		!$past(rst_i) && $changed(fus) |-> $past(test_mode_o)
		&& !$past(vol[LOCK_BIT]))
		else $error("fuse while locked or idle");
	a_fuse_mono: assert property (
		!$past(rst_i) |-> ($past(fus) & ~fus) == '0)
		else $error("fused bit cleared");
	a_fuse_source: assert property (
		!$past(rst_i) |-> (fus & ~($past(fus) | vol)) == '0)
		else $error("fused bit not from volatile");
	a_mag_fields: assert property (
		$stable(vol) |-> left_magnetic_offset_trim_o == vol[27:20]
		&& right_magnetic_offset_trim_o == vol[35:28])
		else $error("magnetic field wrong");
	a_range_sel: assert property (
		$stable(vol) |-> full_scale_range_select_o == vol[FSR_BIT])
		else $error("range select wrong");
	a_gap_limit: assert property (
		gap_q > TIMEOUT_CYCLES + 8 |-> !test_mode_o)
		else $error("frame outlived gap");
	c_read: cover property ($fell(program_serial_line_oe_n_o));
	c_fuse: cover property ($changed(fus));
	c_tout: cover property ($fell(test_mode_o));
endmodule
`default_nettype wire

// [tb/prog_ctrl_model.sv]
`timescale 1ns/10ps
`default_nettype none
module prog_ctrl_model
	import otp_pkg::*;
(
	// programming pins
	output logic              prog_clk_o,
	output logic              hv_entry_o,
	output logic              data_o,
	input  wire logic         line_i,
	// word captured by a read
	output logic [TRIM_W-1:0] rd_o
);
	int half = 16;
	initial begin
		prog_clk_o = 1'b0;
		hv_entry_o = 1'b0;
		data_o     = 1'b0;
		rd_o       = '0;
	end
	task automatic pulse(input logic hv, input logic d, input int n);
		hv_entry_o = hv;
		data_o     = d;
		#(half);
		prog_clk_o = 1'b1;
		#(half);
		prog_clk_o = 1'b0;
		if (n >= READ_FIRST && n <= FRAME_LAST)
			rd_o[n - READ_FIRST] = line_i;
	endtask
	task automatic frame(input logic [7:0] key, input logic [1:0] cmd,
		input logic [TRIM_W-1:0] trm, input int n);
		logic [9:0]   h;
		logic [105:0] b;
		h = {key, cmd};
		b = {trm, CTRL_RESET, 10'h000};
		for (int i = 0; i < 10; i++)
			b[i] = h[9-i];
		// keep the link clock off the system clock's edges
		#3;
		for (int p = 1; p <= n; p++)
			pulse(p == 1, p <= FRAME_LAST ? b[p-1] : 1'b0, p);
	endtask
endmodule
`default_nettype wire

// [tb/tb_otp_trim_port.sv]
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, a) \
	begin \
		n_checks++; \
		if ((a) !== (e)) begin \
			n_errors++; \
			$display("unexpected %s exp %0h got %0h", n, e, a); \
		end \
	end
module tb_otp_trim_port;
	import otp_pkg::*;
	localparam int TO = 200;
	localparam logic [TRIM_W-1:0] P = 80'h0040_e1d2_c3b4_a590_0000;
	logic               clk_i;
	logic               rst_i;
	logic               pclk;
	logic               hv;
	logic               sdo;
	logic               line;
	logic               so;
	logic               oe_n;
	logic               mode;
	logic [CTRL_W-1:0]  ctrl;
	logic [TRIM_W-1:0]  trim;
	logic [TRIM_W-1:0]  fused;
	logic [TRIM_W-1:0]  rd;
	logic [TRIM_W-1:0]  q;
	logic [FIELD_W-1:0] el;
	logic [FIELD_W-1:0] er;
	logic [FIELD_W-1:0] gl;
	logic [FIELD_W-1:0] gr;
	logic [FIELD_W-1:0] ml;
	logic [FIELD_W-1:0] mr;
	logic               fs;
	int                 n_errors = 0;
	int                 n_checks = 0;
	assign line = oe_n ? sdo : so;
	otp_trim_port #(.TIMEOUT_CYCLES(TO)) dut (
		.clk_i, .rst_i, .prog_clk_i(pclk), .hv_entry_i(hv),
		.program_serial_line_i(line), .program_serial_line_o(so),
		.program_serial_line_oe_n_o(oe_n), .test_mode_o(mode),
		.mux_control_word_o(ctrl), .trim_fuse_word_o(trim),
		.fused_trim_word_o(fused), .left_magnetic_offset_trim_o(ml),
		.right_magnetic_offset_trim_o(mr),
		.left_electronic_offset_trim_o(el),
		.right_electronic_offset_trim_o(er),
		.left_gain_trim_o(gl), .right_gain_trim_o(gr),
		.full_scale_range_select_o(fs)
	);
	prog_ctrl_model pc (
		.prog_clk_o(pclk), .hv_entry_o(hv), .data_o(sdo),
		.line_i(line), .rd_o(rd)
	);
	initial begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end
	task automatic complete_run();
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic idle();
		int i = 0;
		while (mode !== 1'b0 && i < TO + 60) begin
			@(negedge clk_i);
			i++;
		end
		if (mode !== 1'b0) begin
			n_errors++;
			complete_run();
		end
	endtask
	task automatic t_write();
		pc.frame(UNLOCK_CODE, CMD_WRITE, P, 109);
		repeat (20) @(negedge clk_i);
		`CHK("mode", 1'b1, mode);
		`CHK("trim", P, trim);
		`CHK("ctrl", CTRL_RESET, ctrl);
		`CHK("elec_l", P[43:36], el);
		`CHK("elec_r", P[51:44], er);
		`CHK("gain_l", P[59:52], gl);
		`CHK("gain_r", P[67:60], gr);
		`CHK("mag_l", P[27:20], ml);
		`CHK("mag_r", P[35:28], mr);
		`CHK("range", P[FSR_BIT], fs);
		idle();
	endtask
	task automatic t_read();
		pc.half = 48;
		pc.frame(UNLOCK_CODE, CMD_READ, ~P, FRAME_LAST);
		`CHK("read", P[78:0], rd[78:0]);
		idle();
		`CHK("oe_n", 1'b1, oe_n);
		pc.half = 16;
	endtask
	task automatic t_refuse();
		for (int k = 0; k < 2; k++) begin
			pc.frame(k ? UNLOCK_CODE : 8'hf3, k ? CMD_NORMAL : CMD_WRITE,
				~P, FRAME_LAST);
			repeat (30) @(negedge clk_i);
			`CHK("mode", 1'b0, mode);
			`CHK("trim", P, trim);
		end
	endtask
	task automatic t_gap();
		// full word resent with one bit altered
		q = P ^ (80'h1 << FSR_BIT);
		pc.frame(UNLOCK_CODE, CMD_WRITE, q, 60);
		`CHK("mode", 1'b1, mode);
		idle();
		`CHK("trim", P, trim);
		pc.frame(UNLOCK_CODE, CMD_WRITE, q, FRAME_LAST);
		idle();
		`CHK("trim", q, trim);
		`CHK("range", q[FSR_BIT], fs);
	endtask
	task automatic t_fuse();
		pc.half = 48;
		pc.frame(UNLOCK_CODE, CMD_FUSE, ~q, FRAME_LAST);
		idle();
		`CHK("fused", q, fused);
		`CHK("trim", q, trim);
		pc.half = 16;
	endtask
	task automatic t_lock();
		q[LOCK_BIT] = 1'b1;
		pc.frame(UNLOCK_CODE, CMD_WRITE, q, FRAME_LAST);
		idle();
		pc.frame(UNLOCK_CODE, CMD_WRITE, P, FRAME_LAST);
		idle();
		`CHK("trim", q, trim);
		pc.frame(UNLOCK_CODE, CMD_FUSE, P, FRAME_LAST);
		idle();
		`CHK("fused", q ^ (80'h1 << LOCK_BIT), fused);
	endtask
	initial begin
		rst_i = 1'b1;
		fork
			begin
				repeat (8) @(negedge clk_i);
				rst_i = 1'b0;
			end
			begin
				// link reset needs programming clock edges
				#3;
				repeat (6) pc.pulse(1'b0, 1'b0, 0);
			end
		join
		idle();
		`CHK("trim", TRIM_RESET, trim);
		`CHK("fused", TRIM_RESET, fused);
		t_write();
		t_read();
		t_refuse();
		t_gap();
		t_fuse();
		t_lock();
		complete_run();
	end
endmodule
bind otp_trim_port otp_trim_port_chk #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) chk (
	.clk_i, .rst_i, .prog_clk_i, .program_serial_line_oe_n_o, .test_mode_o,
	.mux_control_word_o, .trim_fuse_word_o, .fused_trim_word_o,
	.left_magnetic_offset_trim_o, .right_magnetic_offset_trim_o,
	.full_scale_range_select_o
);
`default_nettype wire
